// *** rtl/slave_line_mux.sv ***
// Slave multiplexer end: input fan-in, output steering, lamps
`timescale 1ns/1ps
module char_fifo #(
  parameter int W     = 11,
  parameter int DEPTH = 32
) (
  // Clock and reset
  input  wire logic         sys_clk,
  input  wire logic         srst,
  // Fill side
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  // Drain side
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [AW:0]  wr_ptr_r;
  logic [AW:0]  rd_ptr_r;
  logic         full;
  logic         empty;

  assign empty     = (wr_ptr_r == rd_ptr_r);
  assign full      = (wr_ptr_r[AW] != rd_ptr_r[AW]) &&
                     (wr_ptr_r[AW-1:0] == rd_ptr_r[AW-1:0]);
  assign in_ready  = !full;
  assign out_valid = !empty;
  assign out_data  = mem[rd_ptr_r[AW-1:0]];

  always_ff @(posedge sys_clk) begin
    if (in_valid && !full) begin
      mem[wr_ptr_r[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
    end else begin
      if (in_valid && !full) begin
        wr_ptr_r <= wr_ptr_r + 1'b1;
      end
      if (out_ready && !empty) begin
        rd_ptr_r <= rd_ptr_r + 1'b1;
      end
    end
  end
endmodule

module slave_line_mux
  import slave_mux_pkg::*;
#(
  parameter logic [1:0] CABINET_ID = 2'h0,
  parameter logic [5:0] GROUP_CODE = GRP_LOW
) (
  // Clock and reset
  input  wire logic                           sys_clk,
  input  wire logic                           srst,
  // Link to master end
  mux_link_if.device                          link,
  // Input line units
  input  wire logic [NUM_UNITS-1:0][CHAR_W-1:0] iu_char,
  input  wire logic [NUM_UNITS-1:0]           iu_ready,
  input  wire logic [NUM_UNITS-1:0]           iu_lost,
  input  wire logic [NUM_UNITS-1:0]           iu_break,
  input  wire logic [NUM_UNITS-1:0]           iu_idle,
  output logic      [NUM_UNITS-1:0]           iu_ack,
  // Monitor port
  output logic      [NUM_UNITS-1:0]           monitor_lost,
  // Output line units
  input  wire logic [NUM_UNITS-1:0]           ou_req,
  output logic      [CHAR_W-1:0]              ou_data,
  output logic      [NUM_UNITS-1:0]           ou_ack,
  // Select lamps
  output logic                                lamp_mod_a,
  output logic                                lamp_mod_b,
  output logic      [UNIT_W-1:0]              lamp_pair
);
  localparam int SV = 4 * NUM_UNITS + NUM_UNITS;
  localparam int SS = 5;

  function automatic logic [NUM_UNITS-1:0] unit_decode(
    input logic [UNIT_W-1:0] u
  );
    logic [UNIT_W-1:0] k;
    unit_decode = '0;
    for (int i = 0; i < NUM_UNITS; i++) begin
      k = UNIT_W'(i);
      unit_decode[i] = (k[0] ? u[0] : ~u[0]) &
                       (k[1] ? u[1] : ~u[1]) &
                       (k[2] ? u[2] : ~u[2]);
    end
  endfunction

  logic [SV-1:0]          st_s1_r;
  logic [SV-1:0]          st_s2_r;
  logic [SS-1:0]          sb_s1_r;
  logic [SS-1:0]          sb_s2_r;
  logic [NUM_UNITS-1:0]   rdy_s;
  logic [NUM_UNITS-1:0]   lost_s;
  logic [NUM_UNITS-1:0]   brk_s;
  logic [NUM_UNITS-1:0]   idle_s;
  logic [NUM_UNITS-1:0]   oreq_s;
  logic                   freq_s;
  logic                   poll_s;
  logic                   acc_s;
  logic                   selo_s;
  logic                   oack_s;
  logic                   acc_d_r;
  logic                   oack_d_r;
  logic [NUM_UNITS-1:0]   poll_sel;
  logic [WORD_W-1:0]      fan_word;
  logic                   fan_lost;
  logic                   fan_bi;
  logic                   ack_busy_r;
  logic [ACK_CNT_W-1:0]   ack_cnt_r;
  logic [UNIT_W-1:0]      ack_unit_r;
  logic                   fifo_in_ready;
  logic                   fifo_out_valid;
  logic [FIFO_W-1:0]      fifo_out_data;
  logic                   pop;
  logic [GAP_CNT_W-1:0]   gap_cnt_r;
  logic                   mod_hit;

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      st_s1_r <= '0;
      st_s2_r <= '0;
      sb_s1_r <= '0;
      sb_s2_r <= '0;
    end else begin
      st_s1_r <= {ou_req, iu_idle, iu_break, iu_lost, iu_ready};
      st_s2_r <= st_s1_r;
      sb_s1_r <= {link.func_ready, link.input_req, link.char_accept,
                  link.sel_output, link.out_ack};
      sb_s2_r <= sb_s1_r;
    end
  end

  assign {oreq_s, idle_s, brk_s, lost_s, rdy_s} = st_s2_r;
  assign {freq_s, poll_s, acc_s, selo_s, oack_s} = sb_s2_r;

  assign poll_sel = unit_decode(link.unit_sel) & {NUM_UNITS{poll_s}};

  always_comb begin
    fan_word = '0;
    fan_lost = 1'b0;
    fan_bi   = 1'b0;
    for (int i = 0; i < NUM_UNITS; i++) begin
      if (poll_sel[i]) begin
        fan_word[CHAR_W-1:0] = fan_word[CHAR_W-1:0] | iu_char[i];
        fan_word[READY_BIT]  = fan_word[READY_BIT] | rdy_s[i];
        fan_lost             = fan_lost | lost_s[i];
        fan_bi               = fan_bi | brk_s[i] | idle_s[i];
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      link.in_word    <= '0;
      link.char_lost  <= 1'b0;
      link.break_idle <= 1'b0;
      monitor_lost    <= '0;
    end else begin
      link.in_word    <= fan_word;
      link.char_lost  <= fan_lost;
      link.break_idle <= fan_bi;
      monitor_lost    <= lost_s;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      acc_d_r    <= 1'b0;
      ack_busy_r <= 1'b0;
      ack_cnt_r  <= '0;
      ack_unit_r <= '0;
      iu_ack     <= '0;
    end else begin
      acc_d_r <= acc_s;
      iu_ack  <= '0;
      if (acc_s && !acc_d_r && !ack_busy_r) begin
        ack_busy_r <= 1'b1;
        ack_cnt_r  <= ACK_CNT_W'(ACK_DELAY_CYC - 1);
        ack_unit_r <= link.unit_sel;
      end else if (ack_busy_r) begin
        if (ack_cnt_r == '0) begin
          ack_busy_r <= 1'b0;
          iu_ack     <= unit_decode(ack_unit_r);
        end else begin
          ack_cnt_r <= ack_cnt_r - 1'b1;
        end
      end
    end
  end

  assign mod_hit = (link.fn_code[FC_GRP_HI:FC_GRP_LO] == GROUP_CODE) &&
                   (link.fn_code[FC_CAB_HI:FC_CAB_LO] == CABINET_ID);

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      lamp_mod_a <= 1'b0;
      lamp_mod_b <= 1'b0;
      lamp_pair  <= '0;
    end else if (freq_s && mod_hit) begin
      lamp_mod_a <= ~link.fn_code[FC_MOD_BIT];
      lamp_mod_b <= link.fn_code[FC_MOD_BIT];
      lamp_pair  <= link.fn_code[FC_UNIT_HI:FC_UNIT_LO];
    end else if (!freq_s && link.fn_code == '0) begin
      lamp_mod_a <= 1'b0;
      lamp_mod_b <= 1'b0;
      lamp_pair  <= '0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      link.char_req <= 1'b0;
    end else begin
      link.char_req <= selo_s && fifo_in_ready &&
                       |(oreq_s & unit_decode(link.unit_sel));
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      oack_d_r <= 1'b0;
    end else begin
      oack_d_r <= oack_s;
    end
  end

  char_fifo #(
    .W     (FIFO_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .sys_clk   (sys_clk),
    .srst      (srst),
    .in_valid  (oack_s && !oack_d_r && selo_s),
    .in_ready  (fifo_in_ready),
    .in_data   ({link.unit_sel, link.out_data}),
    .out_valid (fifo_out_valid),
    .out_ready (pop),
    .out_data  (fifo_out_data)
  );

  // Stall until addressed unit requests
  assign pop = fifo_out_valid && (gap_cnt_r == '0) &&
               |(oreq_s & unit_decode(fifo_out_data[FIFO_W-1:CHAR_W]));

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      ou_data   <= '0;
      ou_ack    <= '0;
      gap_cnt_r <= '0;
    end else begin
      ou_ack <= '0;
      if (pop) begin
        ou_data   <= fifo_out_data[CHAR_W-1:0];
        ou_ack    <= unit_decode(fifo_out_data[FIFO_W-1:CHAR_W]);
        gap_cnt_r <= GAP_CNT_W'(OU_GAP_CYC);
      end else if (gap_cnt_r != '0) begin
        gap_cnt_r <= gap_cnt_r - 1'b1;
      end
    end
  end
endmodule

// *** rtl/slave_mux_pkg.sv ***
// Constants shared by both ends of the slave line multiplexer link
package slave_mux_pkg;
  localparam int          NUM_UNITS     = 8;
  localparam int          CHAR_W        = 8;
  localparam int          WORD_W        = 12;
  localparam int          READY_BIT     = 11;
  localparam int          UNIT_W        = 3;
  localparam int          FC_W          = 12;
  // Function code fields: four octal digits
  localparam int          FC_GRP_HI     = 11;
  localparam int          FC_GRP_LO     = 6;
  localparam int          FC_CAB_HI     = 5;
  localparam int          FC_CAB_LO     = 4;
  localparam int          FC_MOD_BIT    = 3;
  localparam int          FC_UNIT_HI    = 2;
  localparam int          FC_UNIT_LO    = 0;
  localparam logic [5:0]  GRP_LOW       = 6'h01;
  localparam logic [5:0]  GRP_HIGH      = 6'h02;
  // Timing
  localparam int          CLK_PERIOD_NS = 40;
  localparam int          ACK_DELAY_NS  = 6000;
  localparam int          ACK_DELAY_CYC =
    (ACK_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          ACK_CNT_W     = 8;
  localparam int          OU_GAP_CYC    = 4;
  localparam int          GAP_CNT_W     = 3;
  // Output character buffer
  localparam int          FIFO_DEPTH    = 32;
  localparam int          FIFO_W        = UNIT_W + CHAR_W;
endpackage

// *** rtl/mux_link_if.sv ***
// Link between master multiplexer end and slave multiplexer end
`timescale 1ns/1ps
interface mux_link_if;
  import slave_mux_pkg::*;
  // Master to slave
  logic              func_ready;
  logic [FC_W-1:0]   fn_code;
  logic [UNIT_W-1:0] unit_sel;
  logic              input_req;
  logic              char_accept;
  logic              sel_output;
  logic              out_ack;
  logic [CHAR_W-1:0] out_data;
  // Slave to master
  logic [WORD_W-1:0] in_word;
  logic              char_lost;
  logic              break_idle;
  logic              char_req;

  modport device (
    input  func_ready, fn_code, unit_sel, input_req, char_accept,
    input  sel_output, out_ack, out_data,
    output in_word, char_lost, break_idle, char_req
  );
  modport master (
    output func_ready, fn_code, unit_sel, input_req, char_accept,
    output sel_output, out_ack, out_data,
    input  in_word, char_lost, break_idle, char_req
  );
endinterface

// *** rtl/master_mux_end.sv ***
// Master multiplexer end: code decode, strobes, output ready
`timescale 1ns/1ps
module master_mux_end
  import slave_mux_pkg::*;
#(
  parameter logic [1:0] CABINET_ID = 2'h0,
  parameter logic       MODULE_B   = 1'b0
) (
  // Clock and reset
  input  wire logic              sys_clk,
  input  wire logic              srst,
  // Link to slave end
  mux_link_if.master             link,
  // Host function and input side
  input  wire logic [FC_W-1:0]   fn_code,
  input  wire logic              func_ready,
  input  wire logic              poll,
  input  wire logic              host_accept,
  output logic      [WORD_W-1:0] host_word,
  output logic                   host_lost,
  output logic                   host_break_idle,
  // Host output side
  input  wire logic              info_ready,
  input  wire logic [CHAR_W-1:0] host_data,
  output logic                   host_char_req,
  output logic                   out_ready
);
  logic grp_ok;
  logic rdy_cond;
  logic rdy_d_r;

  assign grp_ok = (fn_code[FC_GRP_HI:FC_GRP_LO] == GRP_LOW) ||
                  (fn_code[FC_GRP_HI:FC_GRP_LO] == GRP_HIGH);

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      link.unit_sel   <= '0;
      link.sel_output <= 1'b0;
    end else if (func_ready && grp_ok) begin
      link.unit_sel   <= fn_code[FC_UNIT_HI:FC_UNIT_LO];
      link.sel_output <= (fn_code[FC_CAB_HI:FC_CAB_LO] == CABINET_ID) &&
                         (fn_code[FC_MOD_BIT] == MODULE_B);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      link.func_ready  <= 1'b0;
      link.fn_code     <= '0;
      link.input_req   <= 1'b0;
      link.char_accept <= 1'b0;
      host_word        <= '0;
      host_lost        <= 1'b0;
      host_break_idle  <= 1'b0;
      host_char_req    <= 1'b0;
    end else begin
      link.func_ready  <= func_ready;
      link.fn_code     <= fn_code;
      link.input_req   <= poll;
      link.char_accept <= host_accept;
      host_word        <= link.in_word;
      host_lost        <= link.char_lost;
      host_break_idle  <= link.break_idle;
      host_char_req    <= link.char_req;
    end
  end

  assign rdy_cond = info_ready && link.char_req && link.sel_output;

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      rdy_d_r       <= 1'b0;
      out_ready     <= 1'b0;
      link.out_ack  <= 1'b0;
      link.out_data <= '0;
    end else begin
      rdy_d_r      <= rdy_cond;
      out_ready    <= rdy_cond && !rdy_d_r;
      link.out_ack <= rdy_cond && !rdy_d_r;
      if (rdy_cond && !rdy_d_r) begin
        link.out_data <= host_data;
      end
    end
  end
endmodule

// *** verification/mux_link_assertions.sv ***
// Concurrent checks on the link between the master and slave ends
`timescale 1ns/1ps
module mux_link_assertions
  import slave_mux_pkg::*;
(
  // Clock and reset
  input wire logic              sys_clk,
  input wire logic              srst,
  // Master to slave
  input wire logic              func_ready,
  input wire logic [FC_W-1:0]   fn_code,
  input wire logic [UNIT_W-1:0] unit_sel,
  input wire logic              input_req,
  input wire logic              char_accept,
  input wire logic              sel_output,
  input wire logic              out_ack,
  input wire logic [CHAR_W-1:0] out_data,
  // Slave to master
  input wire logic [WORD_W-1:0] in_word,
  input wire logic              char_lost,
  input wire logic              break_idle,
  input wire logic              char_req
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);

  // Poll or output select held low past the sync and register stages
  sequence poll_off_s;
    !input_req [*4];
  endsequence
  sequence unsel_s;
    !sel_output [*4];
  endsequence

  pad_bits_zero_a: assert property (in_word[10:8] == 3'h0)
    else $error("Unused word bits not zero");
  unpolled_quiet_a: assert property (poll_off_s |=>
    (in_word == '0 && !char_lost && !break_idle))
    else $error("Status driven while not polled");
  unsel_no_req_a: assert property (unsel_s |=> !char_req)
    else $error("Character request while module not selected");
  ack_needs_sel_a: assert property (out_ack |-> sel_output)
    else $error("Output acknowledge without select output");
  ack_single_pulse_a: assert property (out_ack |=> !out_ack)
    else $error("Output acknowledge longer than one cycle");
  ack_after_req_a: assert property (out_ack |-> $past(char_req))
    else $error("Output acknowledge without character request");
  unit_sel_code_a: assert property ($changed(unit_sel) |->
    unit_sel == fn_code[FC_UNIT_HI:FC_UNIT_LO])
    else $error("Unit select differs from code unit digit");
  reset_quiet_a: assert property ($fell(srst) |->
    (in_word == '0 && !char_req && !out_ack && !func_ready))
    else $error("Link not quiet after reset");
endmodule

// *** verification/slave_line_multiplexer_tb.sv ***
// Self-checking bench joining master and slave ends over the link
`timescale 1ns/1ps
module slave_line_multiplexer_tb;
  import slave_mux_pkg::*;
  localparam logic [FC_W-1:0] BAD_CODES [3] = '{12'h055, 12'h085, 12'h0C5};

  logic                            sys_clk     = 1'b0;
  logic                            srst        = 1'b1;
  logic [FC_W-1:0]                 fn_code     = '0;
  logic                            func_ready  = 1'b0;
  logic                            poll        = 1'b0;
  logic                            host_accept = 1'b0;
  logic                            info_ready  = 1'b0;
  logic [CHAR_W-1:0]               host_data   = '0;
  logic [NUM_UNITS-1:0][CHAR_W-1:0] iu_char;
  logic [NUM_UNITS-1:0]            iu_ready    = 8'hA5;
  logic [NUM_UNITS-1:0]            iu_lost     = 8'h3C;
  logic [NUM_UNITS-1:0]            iu_break    = 8'h09;
  logic [NUM_UNITS-1:0]            iu_idle     = 8'h60;
  logic [NUM_UNITS-1:0]            ou_req      = '0;
  logic [NUM_UNITS-1:0]            iu_ack;
  logic [NUM_UNITS-1:0]            monitor_lost;
  logic [CHAR_W-1:0]               ou_data;
  logic [NUM_UNITS-1:0]            ou_ack;
  logic                            lamp_mod_a;
  logic                            lamp_mod_b;
  logic [UNIT_W-1:0]               lamp_pair;
  logic [WORD_W-1:0]               host_word;
  logic                            host_lost;
  logic                            host_break_idle;
  logic                            host_char_req;
  logic                            out_ready;
  int                              miscompares     = 0;
  int                              samples_checked = 0;
  int                              ready_pulses    = 0;

  always #20 sys_clk = ~sys_clk;

  // Count master output ready pulses
  always @(posedge sys_clk) begin
    if (out_ready === 1'b1) begin
      ready_pulses <= ready_pulses + 1;
    end
  end

  mux_link_if u_mux_link_if ();

  master_mux_end u_master_mux_end (
    .sys_clk(sys_clk), .srst(srst), .link(u_mux_link_if),
    .fn_code(fn_code), .func_ready(func_ready), .poll(poll),
    .host_accept(host_accept), .host_word(host_word),
    .host_lost(host_lost), .host_break_idle(host_break_idle),
    .info_ready(info_ready), .host_data(host_data),
    .host_char_req(host_char_req), .out_ready(out_ready)
  );

  slave_line_mux u_slave_line_mux (
    .sys_clk(sys_clk), .srst(srst), .link(u_mux_link_if),
    .iu_char(iu_char), .iu_ready(iu_ready), .iu_lost(iu_lost),
    .iu_break(iu_break), .iu_idle(iu_idle), .iu_ack(iu_ack),
    .monitor_lost(monitor_lost), .ou_req(ou_req), .ou_data(ou_data),
    .ou_ack(ou_ack), .lamp_mod_a(lamp_mod_a), .lamp_mod_b(lamp_mod_b),
    .lamp_pair(lamp_pair)
  );

  mux_link_assertions u_mux_link_assertions (
    .sys_clk(sys_clk), .srst(srst),
    .func_ready(u_mux_link_if.func_ready),
    .fn_code(u_mux_link_if.fn_code), .unit_sel(u_mux_link_if.unit_sel),
    .input_req(u_mux_link_if.input_req),
    .char_accept(u_mux_link_if.char_accept),
    .sel_output(u_mux_link_if.sel_output),
    .out_ack(u_mux_link_if.out_ack), .out_data(u_mux_link_if.out_data),
    .in_word(u_mux_link_if.in_word), .char_lost(u_mux_link_if.char_lost),
    .break_idle(u_mux_link_if.break_idle),
    .char_req(u_mux_link_if.char_req)
  );

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic give_verdict();
    if (miscompares == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Function code with strobe, then strobe removed and let settle
  task automatic set_code(input logic [FC_W-1:0] code);
    @(posedge sys_clk);
    fn_code    <= code;
    func_ready <= 1'b1;
    tick(4);
    func_ready <= 1'b0;
    tick(6);
    #1;
  endtask

  task automatic send(input logic [CHAR_W-1:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    host_data  <= d;
    info_ready <= 1'b1;
    do begin
      @(posedge sys_clk);
      #1;
      n++;
    end while (ou_ack === 8'h00 && n < 50);
    chk(16'(ou_ack), 16'h0020);
    chk(16'(ou_data), 16'(d));
    @(posedge sys_clk);
    info_ready <= 1'b0;
    #1;
    chk(16'(ou_ack), 16'h0000);
    tick(8);
  endtask

  initial begin
    repeat (5000) @(posedge sys_clk);
    miscompares++;
    give_verdict();
  end

  initial begin
    int n;
    logic [1:0] flags;
    for (int k = 0; k < NUM_UNITS; k++)
      iu_char[k] = 8'h0F + 8'(k * 33);
    tick(5);
    srst <= 1'b0;
    @(posedge sys_clk);
    #1;
    chk(16'({iu_ack, ou_ack}), 16'h0000);
    chk(16'({host_word, lamp_mod_a, lamp_mod_b, host_char_req}), 16'h0000);
    // lamp decode sweep over units and modules
    for (int i = 0; i < NUM_UNITS; i++) begin
      set_code({GRP_LOW, 2'h0, i[0], 3'(i)});
      chk(16'({lamp_mod_a, lamp_mod_b, lamp_pair}),
          16'({~i[0], i[0], 3'(i)}));
    end
    // wrong cabinet or group leaves lamps dark
    for (int i = 0; i < 3; i++) begin
      set_code('0);
      chk(16'({lamp_mod_a, lamp_mod_b, lamp_pair}), 16'h0000);
      set_code(BAD_CODES[i]);
      chk(16'({lamp_mod_a, lamp_mod_b, lamp_pair}), 16'h0000);
    end
    // fan-in of data and flags from the polled unit
    @(posedge sys_clk);
    poll <= 1'b1;
    for (int u = 0; u < NUM_UNITS; u++) begin
      set_code({GRP_LOW, 2'h0, 1'b0, 3'(u)});
      flags = {iu_lost[u], iu_break[u] | iu_idle[u]};
      chk(16'(host_word), 16'({iu_ready[u], 3'h0, iu_char[u]}));
      chk(16'({host_lost, host_break_idle}), 16'(flags));
    end
    chk(16'(monitor_lost), 16'h003C);
    // acknowledge delay to the selected unit
    @(posedge sys_clk);
    host_accept <= 1'b1;
    n = 0;
    while (u_mux_link_if.char_accept !== 1'b1 && n < 20) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    n = 0;
    do begin
      @(posedge sys_clk);
      #1;
      n++;
    end while (iu_ack === 8'h00 && n < 300);
    chk(16'(n), 16'(ACK_DELAY_CYC + 3));
    chk(16'(iu_ack), 16'h0080);
    @(posedge sys_clk);
    host_accept <= 1'b0;
    #1;
    chk(16'(iu_ack), 16'h0000);
    @(posedge sys_clk);
    poll <= 1'b0;
    tick(6);
    #1;
    chk(16'(host_word), 16'h0000);
    set_code({GRP_LOW, 2'h0, 1'b0, 3'h5});
    @(posedge sys_clk);
    ou_req <= 8'h04;
    tick(8);
    #1;
    chk(16'(host_char_req), 16'h0000);
    @(posedge sys_clk);
    ou_req <= 8'h20;
    tick(8);
    #1;
    chk(16'(host_char_req), 16'h0001);
    send(8'hC3);
    send(8'h3C);
    send(8'h7E);
    chk(16'(ready_pulses), 16'h0003);
    set_code({GRP_LOW, 2'h0, 1'b1, 3'h5});
    tick(6);
    #1;
    chk(16'(host_char_req), 16'h0000);
    give_verdict();
  end
endmodule
